/* File: src/serial_port_pkg.sv */
// Package for the synchronous serial port: register map, field positions,
// reset values, pin types and prescaler decoding.
// Assumes a 32-bit AXI4-Lite master and one system clock.
package serial_port_pkg;

  // Register byte addresses
  localparam logic [3:0] STATUS_ADDR  = 4'h0;
  localparam logic [3:0] CONTROL_ADDR = 4'h4;
  localparam logic [3:0] BUFFER_ADDR  = 4'h8;
  localparam logic [3:0] IRQ_ADDR     = 4'hc;

  // Status register fields
  localparam int ST_ENABLE_BIT   = 15;
  localparam int ST_SIDL_BIT     = 13;
  localparam int ST_ROV_BIT      = 6;
  localparam int ST_TBF_BIT      = 1;
  localparam int ST_RBF_BIT      = 0;

  // Control register fields
  localparam int CT_FRAMING_BIT  = 14;
  localparam int CT_FSD_BIT      = 13;
  localparam int CT_DATA_OUTPUT_DISABLE_BIT   = 11;
  localparam int CT_WIDTH_BIT    = 10;
  localparam int CT_SMP_BIT      = 9;
  localparam int CT_CKE_BIT      = 8;
  localparam int CT_SELECT_PIN_CONTROL_ENABLE_BIT     = 7;
  localparam int CT_CKP_BIT      = 6;
  localparam int CT_MASTER_BIT   = 5;
  localparam int CT_SPRE_LSB     = 2;
  localparam int CT_PPRE_LSB     = 0;
  localparam logic [15:0] CT_WRITE_MASK = 16'h6fff;

  // Interrupt register fields
  localparam int IRQ_FLAG_BIT    = 0;
  localparam int IRQ_ENABLE_BIT  = 1;

  // Reset values
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Fixed module clock division ahead of the prescalers
  localparam int FOSC_DIV        = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        sck_in;
    logic        sdi;
    logic        ss_in;
  } pin_in_t;

  typedef struct packed {
    logic        sck_out;
    logic        sck_oe;
    logic        sdo;
    logic        sdo_oe;
    logic        ss_out;
    logic        ss_oe;
  } pin_out_t;

  // Half period of the serial clock in system clocks
  function automatic logic [10:0] half_period(input logic [1:0] ppre, input logic [2:0] spre);
    logic [10:0] prim;
    logic [10:0] sec;
    prim = 11'h001;
    sec  = 11'h008 - {8'h00, spre};
    unique case (ppre)
      2'h0: prim = 11'h040;
      2'h1: prim = 11'h010;
      2'h2: prim = 11'h004;
      2'h3: prim = 11'h001;
    endcase
    half_period = 11'((FOSC_DIV / 2) * prim * sec);
  endfunction : half_period

endpackage : serial_port_pkg

/* File: src/serial_port.sv */
// Synchronous serial port, master or slave, with AXI4-Lite registers.
// Assumes pins are synchronous to sys_clk and sys_clk is the oscillator clock.
`timescale 1ns/1ps
module serial_port
  import serial_port_pkg::*;
(
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  // Power modes
  input  wire logic                    sleep_mode,
  input  wire logic                    idle_mode,
  // AXI4-Lite write
  input  wire logic [3:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output      logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output      logic                    s_axi_wready,
  output      logic [1:0]              s_axi_bresp,
  output      logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output      logic                    s_axi_arready,
  output      logic [31:0]             s_axi_rdata,
  output      logic [1:0]              s_axi_rresp,
  output      logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Serial pins
  input  wire serial_port_pkg::pin_in_t  pins_in,
  output      serial_port_pkg::pin_out_t pins_out,
  // Interrupt request
  output      logic                    transfer_irq
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic [15:0] sr;
    logic [15:0] txb;
    logic [15:0] rxb;
    logic [15:0] ctrl;
    logic        en;
    logic        sidl;
    logic        rov;
    logic        tbf;
    logic        rbf;
    logic        irq_flag;
    logic        irq_en;
    logic        busy;
    logic        fphase;
    logic        armed;
    logic        synced;
    logic [5:0]  edges;
    logic [4:0]  bits;
    logic [10:0] div;
    logic        sck;
    logic        sdo;
    logic        sck_prev;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  logic        wide;
  logic        cke;
  logic        clock_idle_polarity;
  logic        master;
  logic        framing;
  logic        fsd;
  logic        select_pin_control_enable;
  logic [10:0] hp;
  logic [4:0]  last_bit;
  logic        halted;
  logic        ev_lead;
  logic        ev_trail;
  logic        ev_samp;
  logic        ev_xmit;
  logic        sel_block;
  logic        do_write;
  logic        do_read;
  logic [15:0] wv;
  logic [15:0] new_sr;

  assign wide      = s_q.ctrl[CT_WIDTH_BIT];
  assign cke       = s_q.ctrl[CT_CKE_BIT];
  assign clock_idle_polarity       = s_q.ctrl[CT_CKP_BIT];
  assign master    = s_q.ctrl[CT_MASTER_BIT];
  assign framing   = s_q.ctrl[CT_FRAMING_BIT];
  assign fsd       = s_q.ctrl[CT_FSD_BIT];
  assign select_pin_control_enable      = s_q.ctrl[CT_SELECT_PIN_CONTROL_ENABLE_BIT];
  assign hp        = half_period(s_q.ctrl[CT_PPRE_LSB +: 2], s_q.ctrl[CT_SPRE_LSB +: 3]);
  assign last_bit  = wide ? 5'h0f : 5'h07;
  // Halt freezes the serial engine; disable or sleep additionally aborts below
  assign halted    = !s_q.en || sleep_mode || (idle_mode && s_q.sidl);
  assign sel_block = !master && select_pin_control_enable && !framing && pins_in.ss_in;

  // Handshake outputs straight from state
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign do_read  = s_axi_arvalid && !s_q.rvalid;

  always_comb
  begin
    s_d      = s_q;
    ev_lead  = 1'b0;
    ev_trail = 1'b0;
    ev_samp  = 1'b0;
    ev_xmit  = 1'b0;
    wv       = 16'h0000;
    new_sr   = 16'h0000;

    // Write channels taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;

    // Serial engine; overflow stalls it until the buffer is read
    s_d.sck_prev = pins_in.sck_in;
    if (halted)
    begin
      if (!s_q.en || sleep_mode)
      begin
        s_d.busy   = 1'b0;
        s_d.fphase = 1'b0;
        s_d.armed  = 1'b0;
        s_d.synced = 1'b0;
        s_d.bits   = 5'h00;
        s_d.edges  = 6'h00;
        s_d.div    = 11'h000;
        s_d.sck    = clock_idle_polarity;
      end
    end
    else if (!(s_q.rov && s_q.rbf))
    begin
      if (master)
      begin
        if (!s_q.busy)
        begin
          s_d.sck = clock_idle_polarity;
          if (s_q.tbf && (!framing || !fsd || pins_in.ss_in))
          begin
            s_d.sr     = s_q.txb;
            s_d.tbf    = 1'b0;
            s_d.busy   = 1'b1;
            s_d.fphase = framing && !fsd;
            s_d.armed  = !(framing && !fsd);
            s_d.edges  = 6'h00;
            s_d.bits   = 5'h00;
            s_d.div    = 11'h000;
            if (cke)
              s_d.sdo = wide ? s_q.txb[15] : s_q.txb[7];
          end
        end
        else if (s_q.div == hp - 11'h001)
        begin
          s_d.div = 11'h000;
          s_d.sck = !s_q.sck;
          ev_lead  = (s_q.sck == clock_idle_polarity);
          ev_trail = (s_q.sck != clock_idle_polarity);
          s_d.edges = s_q.edges + 6'h01;
          if (s_q.fphase)
          begin
            ev_lead  = 1'b0;
            ev_trail = 1'b0;
            if (s_q.edges == 6'h01)
            begin
              s_d.fphase = 1'b0;
              s_d.armed  = 1'b1;
              s_d.edges  = 6'h00;
              if (cke)
                s_d.sdo = wide ? s_q.sr[15] : s_q.sr[7];
            end
          end
          else if (s_q.edges == {last_bit, 1'b1})
            s_d.busy = 1'b0;
        end
        else
          s_d.div = s_q.div + 11'h001;
      end
      else
      begin
        ev_lead  = (s_q.sck_prev == clock_idle_polarity) && (pins_in.sck_in != clock_idle_polarity);
        ev_trail = (s_q.sck_prev != clock_idle_polarity) && (pins_in.sck_in == clock_idle_polarity);
        if (sel_block)
        begin
          ev_lead  = 1'b0;
          ev_trail = 1'b0;
          s_d.bits = 5'h00;
          s_d.busy = 1'b0;
        end
        if (framing && fsd)
        begin
          if (pins_in.ss_in && ev_lead)
            s_d.synced = 1'b1;
          if (!s_q.armed && s_q.bits == 5'h00)
          begin
            ev_lead  = 1'b0;
            ev_trail = 1'b0;
          end
        end
        else
          s_d.armed = 1'b1;
        if (!s_q.busy && s_q.bits == 5'h00 && s_q.tbf)
        begin
          s_d.sr  = s_q.txb;
          s_d.tbf = 1'b0;
          if (cke)
            s_d.sdo = wide ? s_q.txb[15] : s_q.txb[7];
        end
        if (s_q.synced && (cke ? ev_trail : ev_lead))
        begin
          s_d.synced = 1'b0;
          s_d.armed  = 1'b1;
        end
      end

      ev_samp = cke ? ev_lead : ev_trail;
      ev_xmit = cke ? ev_trail : ev_lead;
      if (ev_xmit && s_q.armed)
        s_d.sdo = wide ? s_q.sr[15] : s_q.sr[7];
      if (ev_samp && s_q.armed)
      begin
        new_sr = {s_q.sr[14:0], pins_in.sdi};
        s_d.sr = new_sr;
        s_d.bits = s_q.bits + 5'h01;
        if (!master)
          s_d.busy = 1'b1;
        if (s_q.bits == last_bit)
        begin
          // Completes mid last bit in master mode only with cke set; with cke clear, on the last edge
          s_d.bits = 5'h00;
          s_d.irq_flag = 1'b1;
          if (!master)
          begin
            s_d.busy = 1'b0;
            s_d.armed = !(framing && fsd);
          end
          if (s_q.rbf)
            s_d.rov = 1'b1;
          else
          begin
            s_d.rxb = wide ? new_sr : {8'h00, new_sr[7:0]};
            s_d.rbf = 1'b1;
          end
          if (s_q.tbf)
          begin
            s_d.sr  = s_q.txb;
            s_d.tbf = 1'b0;
            if (cke)
              s_d.sdo = wide ? s_q.txb[15] : s_q.txb[7];
          end
        end
      end
    end

    // Register write; hardware set takes priority over software clear
    if (do_write)
    begin
      s_d.w_got  = 1'b0;
      s_d.aw_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case (s_q.waddr)
        STATUS_ADDR:
        begin
          wv = merge({s_q.en, 1'b0, s_q.sidl, 6'h00, s_q.rov, 6'h00}, s_q.wdata, s_q.wstrb);
          s_d.en   = wv[ST_ENABLE_BIT];
          s_d.sidl = wv[ST_SIDL_BIT];
          s_d.rov  = (s_q.rov && wv[ST_ROV_BIT]) || s_d.rov;
        end
        CONTROL_ADDR:
        begin
          wv = merge(s_q.ctrl, s_q.wdata, s_q.wstrb) & CT_WRITE_MASK;
          s_d.ctrl = wv;
          if (wv[CT_WIDTH_BIT] != wide)
          begin
            s_d.busy   = 1'b0;
            s_d.fphase = 1'b0;
            s_d.armed  = 1'b0;
            s_d.synced = 1'b0;
            s_d.bits   = 5'h00;
            s_d.edges  = 6'h00;
            s_d.div    = 11'h000;
            s_d.rbf    = 1'b0;
            s_d.tbf    = 1'b0;
            s_d.rov    = 1'b0;
            s_d.sck    = wv[CT_CKP_BIT];
          end
        end
        BUFFER_ADDR:
        begin
          s_d.txb = merge(s_q.txb, s_q.wdata, s_q.wstrb);
          s_d.tbf = 1'b1;
        end
        IRQ_ADDR:
        begin
          s_d.irq_en = s_q.wstrb[0] ? s_q.wdata[IRQ_ENABLE_BIT] : s_q.irq_en;
          if (s_q.wstrb[0] && s_q.wdata[IRQ_FLAG_BIT] && !(s_d.irq_flag && !s_q.irq_flag))
            s_d.irq_flag = 1'b0;
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end

    // Register read; reading the buffer frees the receive path
    if (do_read)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        STATUS_ADDR:  s_d.rdata = {16'h0000, s_q.en, 1'b0, s_q.sidl, 6'h00, s_q.rov,
                                   4'h0, s_q.tbf, s_q.rbf};
        CONTROL_ADDR: s_d.rdata = {16'h0000, s_q.ctrl};
        BUFFER_ADDR:
        begin
          s_d.rdata = {16'h0000, s_q.rxb};
          if (!(s_d.rbf && !s_q.rbf))
            s_d.rbf = 1'b0;
        end
        IRQ_ADDR:     s_d.rdata = {30'h0000_0000, s_q.irq_en, s_q.irq_flag};
        default:      s_d.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.ctrl <= REG_RESET;
      s_q.txb  <= REG_RESET;
      s_q.rxb  <= REG_RESET;
    end
    else
      s_q <= s_d;
  end

  // Pin drivers
  assign pins_out.sck_out = s_q.sck;
  assign pins_out.sck_oe  = s_q.en && master;
  assign pins_out.sdo     = s_q.sdo;
  assign pins_out.sdo_oe  = s_q.en && !sleep_mode && !s_q.ctrl[CT_DATA_OUTPUT_DISABLE_BIT] && !sel_block;
  assign pins_out.ss_out  = s_q.fphase;
  assign pins_out.ss_oe   = s_q.en && framing && !fsd;
  assign transfer_irq     = s_q.irq_flag && s_q.irq_en;

endmodule : serial_port

/* File: bench/serial_port_chk.sv */
// Checker for the serial port: bus handshakes, serial clock rate, sleep.
// Bound to serial_port; sees only its ports.
`timescale 1ns/1ps
module serial_port_chk
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // Watched ports
  input wire logic        sleep_mode,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire pin_out_t    pins_out
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid fell");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid fell");

  property p_b_late;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_late: assert property (p_b_late) else $error("no write answer");

  property p_r_late;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_late: assert property (p_r_late) else $error("no read answer");

  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken early");

  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken early");

  // Two cycles of sleep leave room for a registered enable
  property p_sleep_off;
    sleep_mode ##1 sleep_mode |-> !pins_out.sdo_oe;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("output driven in sleep");

  // Shortest half period is two system clocks
  property p_sck_rate;
    pins_out.sck_oe && $past(pins_out.sck_oe) && $changed(pins_out.sck_out)
      |=> $stable(pins_out.sck_out);
  endproperty
  a_sck_rate: assert property (p_sck_rate) else $error("serial clock too fast");
endmodule : serial_port_chk

bind serial_port serial_port_chk serial_port_chk_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .sleep_mode(sleep_mode),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .pins_out(pins_out)
);

/* File: bench/spi_peer.sv */
// Far-side serial peripheral, used with the port in master mode.
// Assumes the port's serial clock is registered on sys_clk.
`timescale 1ns/1ps
module spi_peer (
  // Clock
  input  wire logic        sys_clk,
  // Pins
  input  wire logic        sck,
  input  wire logic        sdo,
  output      logic        sdi,
  // Setup
  input  wire logic        width16,
  input  wire logic        clock_idle_polarity,
  input  wire logic        load,
  input  wire logic [15:0] load_word,
  output      logic [15:0] rx_word
);
  logic        sck_q;
  logic [15:0] tx_q;

  // The clock is only listened to; the master owns it
  assign sdi = width16 ? tx_q[15] : tx_q[7];
  always_ff @(posedge sys_clk)
  begin
    sck_q <= sck;
    if (load)
    begin
      tx_q    <= load_word;
      rx_word <= 16'h0000;
    end
    else if (sck != sck_q && sck != clock_idle_polarity)
      rx_word <= {rx_word[14:0], sdo};
    else if (sck != sck_q)
      tx_q <= {tx_q[14:0], ~tx_q[0]};
  end
endmodule : spi_peer

/* File: bench/spi_master_slave_port_tb_top.sv */
// Testbench: AXI4-Lite master, far-side peer, row loop and corner cases.
// Assumes a 250 MHz sys_clk; the port runs master mode against the peer.
`timescale 1ns/1ps
module spi_master_slave_port_tb_top;
  import serial_port_pkg::*;
  typedef struct packed {
    logic [15:0] ctl;
    logic [15:0] tx;
    logic [15:0] pw;
    logic [15:0] rx;
    logic [15:0] prx;
  } row_t;
  localparam row_t ROWS [5] = '{
    '{16'h053f, 16'ha5c3, 16'h3c96, 16'h3c96, 16'ha5c3},
    '{16'h017f, 16'h125a, 16'h77e1, 16'h00e1, 16'h005a},
    '{16'h057b, 16'h8001, 16'hfffe, 16'hfffe, 16'h8001},
    '{16'h013e, 16'h00ff, 16'h0080, 16'h0080, 16'h00ff},
    '{16'h043f, 16'h1234, 16'hbeef, 16'hbeef, 16'h1234}
  };
  logic        sys_clk, arst_n, sleep_mode, idle_mode, ss_in, p_load;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [1:0]  rs;
  logic [15:0] p_word, ctl;
  wire         awready, wready, bvalid, arready, rvalid, irq, p_sdi;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] p_rx;
  pin_out_t    pin_o;
  int          n_errors, n_checks;

  serial_port serial_port_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins_in({1'b0, p_sdi, ss_in}), .pins_out(pin_o), .transfer_irq(irq)
  );
  spi_peer spi_peer_i (
    .sys_clk(sys_clk), .sck(pin_o.sck_out), .sdo(pin_o.sdo), .sdi(p_sdi),
    .width16(ctl[10]), .clock_idle_polarity(ctl[6]), .load(p_load), .load_word(p_word), .rx_word(p_rx)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic stuck;
    n_errors++;
    $display("mismatch wait expected done seen timeout");
    print_verdict();
  endtask : stuck

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    int i;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
    bready <= 1'b0;
    if (i == 40) stuck();
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 40) stuck();
  endtask : rdr

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    rdr(a, rd, rs);
    chk($sformatf("reg %h", a), {16'h0000, e}, rd);
  endtask : rchk

  // Port is disabled before each control change, as width changes demand
  task automatic cfg(input logic [15:0] c);
    ctl = c;
    wr(STATUS_ADDR, 16'h0000);
    wr(CONTROL_ADDR, c);
    wr(STATUS_ADDR, 16'h8000);
    wr(IRQ_ADDR, 16'h0003);
  endtask : cfg

  task automatic send(input logic [15:0] t, input logic [15:0] p);
    p_word <= p;
    p_load <= 1'b1;
    @(posedge sys_clk);
    p_load <= 1'b0;
    wr(BUFFER_ADDR, t);
  endtask : send

  task automatic poll(input int b);
    int i;
    rd = '0;
    for (i = 0; i < 300 && rd[b] !== 1'b1; i++)
      rdr(STATUS_ADDR, rd, rs);
    if (i == 300) stuck();
  endtask : poll

  initial
  begin
    {sys_clk, arst_n, sleep_mode, idle_mode, p_load} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, p_word, ctl} = '0;
    ss_in = 1'b1;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 4; k++)
      rchk(4'(k * 4), REG_RESET);
    rdr(4'h2, rd, rs);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
    // Each row: transfer, then the buffer is read, as transmit-only users must
    foreach (ROWS[k])
    begin
      cfg(ROWS[k].ctl);
      send(ROWS[k].tx, ROWS[k].pw);
      poll(ST_RBF_BIT);
      chk("irq", 32'h1, {31'h0, irq});
      rchk(STATUS_ADDR, 16'h8001);
      rchk(BUFFER_ADDR, ROWS[k].rx);
      chk("peer", {16'h0, ROWS[k].prx}, {16'h0, p_rx});
      rchk(STATUS_ADDR, 16'h8000);
    end
    $display("test rows done");
    cfg(ROWS[0].ctl);
    send(16'h1111, 16'h2222);
    poll(ST_RBF_BIT);
    send(16'h3333, 16'h4444);
    poll(ST_ROV_BIT);
    send(16'h5555, 16'h6666);
    repeat (100) @(posedge sys_clk);
    rchk(STATUS_ADDR, 16'h8043);
    rchk(BUFFER_ADDR, 16'h2222);
    wr(IRQ_ADDR, 16'h0000);
    @(negedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk(IRQ_ADDR, 16'h0001);
    $display("test overflow done");
    cfg(ROWS[0].ctl);
    @(negedge sys_clk);
    chk("oe master", 32'h3, {30'h0, pin_o.sck_oe, pin_o.sdo_oe});
    cfg(ROWS[0].ctl | 16'h0800);
    @(negedge sys_clk);
    chk("oe disabled", 32'h2, {30'h0, pin_o.sck_oe, pin_o.sdo_oe});
    cfg(16'h0180);
    @(negedge sys_clk);
    chk("oe deselected", 32'h0, {30'h0, pin_o.sck_oe, pin_o.sdo_oe});
    @(posedge sys_clk);
    ss_in <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("oe selected", 32'h1, {30'h0, pin_o.sck_oe, pin_o.sdo_oe});
    @(posedge sys_clk);
    ss_in <= 1'b1;
    $display("test pins done");
    cfg(ROWS[3].ctl);
    send(16'h0f0f, 16'h0000);
    repeat (20) @(posedge sys_clk);
    sleep_mode <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("oe sleep", 32'h0, {31'h0, pin_o.sdo_oe});
    rchk(CONTROL_ADDR, ROWS[3].ctl);
    @(posedge sys_clk);
    sleep_mode <= 1'b0;
    $display("test sleep done");
    // Stop-in-idle holds a pending word until idle ends
    wr(STATUS_ADDR, 16'ha000);
    idle_mode <= 1'b1;
    wr(BUFFER_ADDR, 16'h00c3);
    repeat (50) @(posedge sys_clk);
    rchk(STATUS_ADDR, 16'ha002);
    @(posedge sys_clk);
    idle_mode <= 1'b0;
    poll(ST_RBF_BIT);
    rchk(STATUS_ADDR, 16'ha001);
    $display("test idle done");
    print_verdict();
  end
endmodule : spi_master_slave_port_tb_top
